// ### hw/tdsb_axil_slave.sv
/*
 * AXI4-Lite slave front end: turns bus transfers into one-cycle write and
 * read requests. Assumes the register file answers a read request with
 * registered data and error one cycle later, held until the next request.
 */
`timescale 1ns/1ps
module tdsb_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tdsb_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tdsb_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_req,
	output logic [tdsb_pkg::AXI_AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic rd_req,
	output logic [tdsb_pkg::AXI_AW-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);
	import tdsb_pkg::*;

	// ------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------
	logic aw_held;
	logic w_held;
	tdsb_rd_e rd_st;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_req = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			wr_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			wr_addr <= s_axi_awaddr;
		end else if (wr_req) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wr_data <= '0;
			wr_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			wr_data <= s_axi_wdata;
			wr_strb <= s_axi_wstrb;
		end else if (wr_req) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_req) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	assign s_axi_arready = (rd_st == TDSB_RD_IDLE);
	assign rd_req = (rd_st == TDSB_RD_WAIT);
	assign s_axi_rvalid = (rd_st == TDSB_RD_RESP);
	assign s_axi_rdata = rd_data;
	assign s_axi_rresp = rd_err ? RESP_SLVERR : RESP_OKAY;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_st <= TDSB_RD_IDLE;
			rd_addr <= '0;
		end else begin
			case (rd_st)
				TDSB_RD_IDLE: begin
					if (s_axi_arvalid) begin
						rd_st <= TDSB_RD_WAIT;
						rd_addr <= s_axi_araddr;
					end
				end
				TDSB_RD_WAIT: rd_st <= TDSB_RD_RESP;
				TDSB_RD_RESP: begin
					if (s_axi_rready) begin
						rd_st <= TDSB_RD_IDLE;
					end
				end
				default: rd_st <= TDSB_RD_IDLE;
			endcase
		end
	end
endmodule

// ### hw/tdsb_pkg.sv
/*
 * Shared constants for the thread debug step/breakpoint block: register map,
 * field positions, reset values, bus answers and the read-path states.
 * Assumes a 32-bit AXI4-Lite register bus and one core clock.
 */
package tdsb_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int THREADS = 8;
	localparam int TID_W = 3;
	localparam int IA_W = 16;
	localparam int DW = 32;
	localparam int AXI_AW = 12;
	localparam int MIR_AW = 6;
	localparam int MIR_DEPTH = 64;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFF_STEP_EN = 12'h000;
	localparam logic [11:0] OFF_EXC_MASK = 12'h004;
	localparam logic [11:0] OFF_STEP_CMD = 12'h008;
	localparam logic [11:0] OFF_BP_ADDR = 12'h00c;
	localparam logic [11:0] OFF_BP_CTRL = 12'h010;
	localparam logic [11:0] OFF_STEP_ACT = 12'h014;
	localparam logic [11:0] OFF_EXC_HALT = 12'h018;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h01c;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h020;
	localparam logic [11:0] OFF_BP_THREAD = 12'h024;
	localparam logic [11:0] OFF_MIR_BASE = 12'h100;
	localparam logic [11:0] MIR_WIN_MASK = 12'hf00;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int BP_ENA_BIT = 0;
	localparam int IRQ_BP_BIT = 0;
	localparam int IRQ_STEP_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [7:0] THR_RST = 8'h00;
	localparam logic [15:0] BP_ADDR_RST = 16'h0000;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// ------------------------------------------------------------
	// Bus answers and read-path states
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {TDSB_RD_IDLE, TDSB_RD_WAIT, TDSB_RD_RESP} tdsb_rd_e;
endpackage

// ### hw/tdsb_reg_mirror.sv
/*
 * Read-only mirror of processor and coprocessor scalar/array registers.
 * Assumes the processor side pushes every register update on the write
 * port in the core clock domain; the read data come out of a register.
 */
`timescale 1ns/1ps
module tdsb_reg_mirror (
	input wire logic aclk,
	input wire logic wr_en,
	input wire logic [tdsb_pkg::MIR_AW-1:0] wr_idx,
	input wire logic [tdsb_pkg::DW-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [tdsb_pkg::MIR_AW-1:0] rd_idx,
	output logic [tdsb_pkg::DW-1:0] rd_data
);
	import tdsb_pkg::*;

	logic [DW-1:0] mem [MIR_DEPTH];

	// No reset: contents only mean anything once the processor wrote them
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (rd_en) begin
			rd_data <= mem[rd_idx];
		end
	end
endmodule

// ### hw/tdsb_thread_debug.sv
/*
 * Per-thread single step and shared instruction breakpoint for the
 * picoprocessor threads, plus a read-only register mirror, on AXI4-Lite.
 * Assumes thread fetch/address inputs and mirror updates come from logic
 * on the same core clock; each thread executes only while its run bit is high.
 */
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Contract
// RQ1 - Each thread can be put into single step independently of others.
// RQ2 - One step advances a stepping thread by exactly one instruction.
// RQ3 - Stepping never stalls or gates coprocessor operations.
// RQ4 - Step-enable mask, one bit per thread, read/write, forces stepping.
// RQ5 - Step-on-exception mask picks threads that step on debug interrupt.
// RQ6 - A stepping thread moves only on a step command register write.
// RQ7 - One breakpoint comparator shared by all threads. The code has one comparator per thread against the one shared bp_addr.
// RQ8 - A thread address equal to breakpoint raises a debug-class interrupt.
// RQ9 - On that interrupt, threads set in exception mask enter stepping.
// RQ10 - The breakpoint address sits in a software-writable register.
// RQ11 - Processor and coprocessor registers are readable on the bus.
// RQ12 - Mirrored general registers are read-only; bus writes never change them.
// RQ13 - Both step masks clear at reset so all threads run freely.
module tdsb_thread_debug (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tdsb_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tdsb_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [tdsb_pkg::THREADS*tdsb_pkg::IA_W-1:0] thread_iaddr,
	input wire logic [tdsb_pkg::THREADS-1:0] thread_fetch,
	output logic [tdsb_pkg::THREADS-1:0] thread_run,
	output logic debug_irq_pulse,
	output logic irq,
	input wire logic mirror_wr_en,
	input wire logic [tdsb_pkg::MIR_AW-1:0] mirror_wr_idx,
	input wire logic [31:0] mirror_wr_data
);
	import tdsb_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] strb_merge(input logic [31:0] old,
			input logic [31:0] nv, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nv[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] pad_thr(input logic [THREADS-1:0] v);
		return {{(32-THREADS){1'b0}}, v};
	endfunction

	function automatic logic [TID_W-1:0] first_idx(input logic [THREADS-1:0] v);
		logic [TID_W-1:0] r;
		r = '0;
		for (int t = THREADS - 1; t >= 0; t--) begin
			if (v[t]) begin
				r = TID_W'(t);
			end
		end
		return r;
	endfunction

	function automatic logic [IA_W-1:0] lane(input logic [THREADS*IA_W-1:0] f,
			input logic [TID_W-1:0] i);
		return f[i*IA_W +: IA_W];
	endfunction

	// ------------------------------------------------------------
	// Bus front end and mirror
	// ------------------------------------------------------------
	logic wr_req;
	logic [AXI_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_req;
	logic [AXI_AW-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	logic [31:0] mir_rdata;

	tdsb_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_req(wr_req),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_req(rd_req),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	wire [11:0] wa = {wr_addr[11:2], 2'b00};
	wire [11:0] ra = {rd_addr[11:2], 2'b00};
	wire rd_mir = (ra & MIR_WIN_MASK) == OFF_MIR_BASE;
	wire wr_mir = (wa & MIR_WIN_MASK) == OFF_MIR_BASE;

	tdsb_reg_mirror u_mirror (
		.aclk(aclk),
		.wr_en(mirror_wr_en),
		.wr_idx(mirror_wr_idx),
		.wr_data(mirror_wr_data),
		.rd_en(rd_req && rd_mir), // [RQ11]
		.rd_idx(ra[MIR_AW+1:2]),
		.rd_data(mir_rdata)
	);

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	wire we_en = wr_req && wa == OFF_STEP_EN;
	wire we_exc = wr_req && wa == OFF_EXC_MASK;
	wire we_cmd = wr_req && wa == OFF_STEP_CMD;
	wire we_bpa = wr_req && wa == OFF_BP_ADDR;
	wire we_bpc = wr_req && wa == OFF_BP_CTRL;
	wire we_halt = wr_req && wa == OFF_EXC_HALT;
	wire we_stat = wr_req && wa == OFF_IRQ_STAT;
	wire we_mask = wr_req && wa == OFF_IRQ_MASK;
	// Mirror window and status-only registers refuse writes [RQ12]
	assign wr_err = !(we_en || we_exc || we_cmd || we_bpa || we_bpc || we_halt
		|| we_stat || we_mask);
	wire [THREADS-1:0] wr_thr = wr_data[THREADS-1:0];
	wire lane0 = wr_strb[0];

	// ------------------------------------------------------------
	// Step control
	// ------------------------------------------------------------
	logic [THREADS-1:0] step_en;
	logic [THREADS-1:0] exc_mask;
	logic [THREADS-1:0] exc_halt;
	logic [THREADS-1:0] step_pulse;
	logic [IA_W-1:0] bp_addr;
	logic bp_ena;
	logic [THREADS-1:0] bp_hit;
	logic [TID_W-1:0] bp_thread;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;

	wire [THREADS-1:0] step_mode = step_en | exc_halt; // [RQ1]
	wire [THREADS-1:0] step_go = (we_cmd && lane0) ? (wr_thr & step_mode) : '0; // [RQ6]
	// Only the sequencer is held; coprocessors keep their own pace [RQ3]
	assign thread_run = ~step_mode | step_pulse; // [RQ2] [RQ6]
	wire bp_any = |bp_hit;
	wire [THREADS-1:0] halt_set = bp_any ? exc_mask : '0; // [RQ9]
	wire [THREADS-1:0] halt_clr = (we_halt && lane0) ? wr_thr : '0;
	wire [THREADS-1:0] next_exc_halt = (exc_halt & ~halt_clr) | halt_set;
	wire [IRQ_W-1:0] irq_evt = {|step_pulse, bp_any};
	wire [IRQ_W-1:0] stat_clr = (we_stat && lane0) ? wr_data[IRQ_W-1:0] : '0;
	// Hardware set wins over a same-cycle software clear
	wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~stat_clr) | irq_evt;
	wire [31:0] step_en_m = strb_merge(pad_thr(step_en), wr_data, wr_strb);
	wire [31:0] exc_mask_m = strb_merge(pad_thr(exc_mask), wr_data, wr_strb);
	wire [31:0] bp_addr_m = strb_merge(32'(bp_addr), wr_data, wr_strb);

	// One comparator per thread against the single shared bp_addr; a thread only hits on an instruction it issues
	always_comb begin
		bp_hit = '0;
		for (int t = 0; t < THREADS; t++) begin
			bp_hit[t] = bp_ena && thread_fetch[t] && thread_run[t]
				&& lane(thread_iaddr, TID_W'(t)) == bp_addr; // [RQ7]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_en <= THR_RST; // [RQ13]
			exc_mask <= THR_RST; // [RQ13]
		end else begin
			if (we_en) step_en <= step_en_m[THREADS-1:0]; // [RQ4]
			if (we_exc) exc_mask <= exc_mask_m[THREADS-1:0]; // [RQ5]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			exc_halt <= THR_RST;
			step_pulse <= THR_RST;
		end else begin
			exc_halt <= next_exc_halt;
			step_pulse <= step_go; // [RQ2]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bp_addr <= BP_ADDR_RST;
			bp_ena <= 1'b0;
		end else begin
			if (we_bpa) bp_addr <= bp_addr_m[IA_W-1:0]; // [RQ10]
			if (we_bpc && lane0) bp_ena <= wr_data[BP_ENA_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			debug_irq_pulse <= 1'b0;
			bp_thread <= '0;
			irq_stat <= IRQ_RST;
			irq_mask <= IRQ_RST;
		end else begin
			debug_irq_pulse <= bp_any; // [RQ8]
			if (bp_any) bp_thread <= first_idx(bp_hit);
			irq_stat <= next_irq_stat;
			if (we_mask && lane0) irq_mask <= wr_data[IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	wire [31:0] reg_rdata =
		(ra == OFF_STEP_EN) ? pad_thr(step_en) :
		(ra == OFF_EXC_MASK) ? pad_thr(exc_mask) :
		(ra == OFF_BP_ADDR) ? 32'(bp_addr) :
		(ra == OFF_BP_CTRL) ? 32'(bp_ena) :
		(ra == OFF_STEP_ACT) ? pad_thr(step_mode) :
		(ra == OFF_EXC_HALT) ? pad_thr(exc_halt) :
		(ra == OFF_IRQ_STAT) ? 32'(irq_stat) :
		(ra == OFF_IRQ_MASK) ? 32'(irq_mask) :
		(ra == OFF_BP_THREAD) ? 32'(bp_thread) : 32'h0000_0000;
	wire rd_map = rd_mir || ra == OFF_STEP_CMD || ra <= OFF_BP_THREAD;
	logic [31:0] reg_rd_q;
	logic rd_mir_q;
	logic rd_err_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_rd_q <= '0;
			rd_mir_q <= 1'b0;
			rd_err_q <= 1'b0;
		end else if (rd_req) begin
			reg_rd_q <= reg_rdata;
			rd_mir_q <= rd_mir;
			rd_err_q <= !rd_map;
		end
	end

	assign rd_data = rd_mir_q ? mir_rdata : reg_rd_q;
	assign rd_err = rd_err_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_reset_masks_clear: assert property ($rose(aresetn) |-> step_en == '0 && exc_mask == '0) // [RQ13]
		else $error("step masks not clear after reset");
	a_step_only_cmd: assert property (|(thread_run & step_mode) |-> $past(we_cmd)) // [RQ6]
		else $error("stepping thread ran without a step command");
	a_step_one_instr: assert property (|step_go |=> // [RQ2]
		(thread_run & $past(step_go)) == $past(step_go)
		##1 (step_mode & $past(step_go, 2) & thread_run) == '0)
		else $error("step did not give exactly one instruction");
	a_step_independent: assert property (|step_go |=> // [RQ1]
		(thread_run & step_mode & ~$past(step_go)) == '0)
		else $error("step command moved another thread");
	a_enable_mask_write: assert property (we_en && lane0 |=> step_en == $past(wr_thr)) // [RQ4]
		else $error("step enable mask not updated");
	a_bp_enter_step: assert property (bp_any |=> // [RQ9]
		(exc_halt & $past(exc_mask)) == $past(exc_mask))
		else $error("breakpoint did not halt masked threads");
	a_bp_irq_pulse: assert property (bp_any |=> // [RQ8]
		debug_irq_pulse ##1 (debug_irq_pulse == $past(bp_any)))
		else $error("debug interrupt not raised on breakpoint");
	a_bp_compare: assert property (bp_any |-> // [RQ7]
		bp_ena && lane(thread_iaddr, first_idx(bp_hit)) == bp_addr)
		else $error("breakpoint hit without address match");
	a_mirror_ro: assert property (wr_req && wr_mir |=> // [RQ12]
		s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
		else $error("write to mirror window accepted");
	a_mirror_read: assert property (rd_req && rd_mir |=> // [RQ11]
		s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata == mir_rdata)
		else $error("mirror read not served");

	c_bp_hit: cover property (bp_any ##1 debug_irq_pulse);
	c_step_taken: cover property (|step_go ##1 |(thread_run & step_mode));
	c_irq_out: cover property ($rose(irq));
	c_mirror_read: cover property (rd_req && rd_mir);
endmodule

// ### tb/tb.sv
/*
 * Self-checking bench for the thread debug step/breakpoint block.
 * Assumes tdsb_pkg, the design files and the thread model compile first.
 */
`timescale 1ns/1ps
module tb;
	import tdsb_pkg::*;
	typedef struct {logic [31:0] d; logic [1:0] r;} tdsb_exp_s;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, debug_irq_pulse, irq, mirror_wr_en;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, mirror_wr_data, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [THREADS*IA_W-1:0] thread_iaddr, a0, a1;
	logic [7:0] thread_fetch, thread_run, want, m, c, e;
	logic [5:0] mirror_wr_idx, k;
	logic [15:0] bp;
	tdsb_exp_s x;
	tdsb_exp_s q_rd[$];
	logic [1:0] q_wr[$];
	int err_total = 0;
	int checked = 0;
	int n;
	localparam logic [11:0] RST_OFF [9] = '{OFF_STEP_EN, OFF_EXC_MASK, OFF_STEP_CMD,
		OFF_BP_ADDR, OFF_BP_CTRL, OFF_STEP_ACT, OFF_EXC_HALT, OFF_IRQ_STAT, OFF_IRQ_MASK};

	tdsb_thread_debug uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .thread_iaddr(thread_iaddr),
		.thread_fetch(thread_fetch), .thread_run(thread_run),
		.debug_irq_pulse(debug_irq_pulse), .irq(irq), .mirror_wr_en(mirror_wr_en),
		.mirror_wr_idx(mirror_wr_idx), .mirror_wr_data(mirror_wr_data));

	tdsb_thread_model u_threads (.aclk(aclk), .aresetn(aresetn), .want(want),
		.thread_run(thread_run), .thread_iaddr(thread_iaddr), .thread_fetch(thread_fetch));

	// ------------------------------------------------------------
	// Clock, verdict and compares
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic tally_and_finish();
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic cmp_bus(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic cmp_pin(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// A wait that runs out counts as a mismatch and ends the run
	task automatic guard(inout int cnt);
		cnt++;
		if (cnt > 500) begin
			err_total++;
			tally_and_finish();
		end
	endtask

	// ------------------------------------------------------------
	// Bus master; ready is looked at on the falling edge so the
	// decision never races the rising edge that moves the item
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int cnt;
		logic pa, pw, ta, tw;
		cnt = 0;
		pa = 1'b1;
		pw = 1'b1;
		q_wr.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			guard(cnt);
			ta = pa && s_axi_awready === 1'b1;
			tw = pw && s_axi_wready === 1'b1;
			@(posedge aclk);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				s_axi_wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do begin
			@(negedge aclk);
			guard(cnt);
		end while (s_axi_bvalid !== 1'b1);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int cnt;
		cnt = 0;
		q_rd.push_back('{d, r});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			guard(cnt);
		end while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			guard(cnt);
		end while (s_axi_rvalid !== 1'b1);
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask

	// Watcher: each answer is matched against the oldest note
	always @(negedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			x = q_rd.pop_front();
			cmp_bus("rdata", x.d, s_axi_rdata);
			cmp_bus("rresp", {30'h0, x.r}, {30'h0, s_axi_rresp});
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			cmp_bus("bresp", {30'h0, q_wr.pop_front()}, {30'h0, s_axi_bresp});
	end

	initial begin
		#300000;
		err_total++;
		tally_and_finish();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, mirror_wr_en} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, mirror_wr_idx, mirror_wr_data} = '0;
		s_axi_wstrb = 4'hf;
		want = 8'hff;
		void'($urandom(86393));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (RST_OFF[i]) rd(RST_OFF[i], 32'h0, RESP_OKAY);
		@(negedge aclk);
		cmp_pin("run_reset", 32'hff, {24'h0, thread_run});
		m = 8'($urandom) | 8'h01;
		c = 8'($urandom) | 8'h01;
		wr(OFF_STEP_EN, {24'h0, m}, RESP_OKAY);
		rd(OFF_STEP_EN, {24'h0, m}, RESP_OKAY);
		@(negedge aclk);
		cmp_pin("run_mask", {24'h0, ~m}, {24'h0, thread_run});
		a0 = thread_iaddr;
		repeat (6) @(negedge aclk);
		wr(OFF_STEP_CMD, {24'h0, c}, RESP_OKAY);
		repeat (3) @(negedge aclk);
		a1 = thread_iaddr;
		for (int t = 0; t < THREADS; t++)
			if (m[t])
				cmp_pin("step", {31'h0, c[t]}, {16'h0, a1[t*IA_W+:IA_W] - a0[t*IA_W+:IA_W]});
		rd(OFF_IRQ_STAT, 32'h2, RESP_OKAY);
		e = 8'($urandom) | 8'h80;
		wr(OFF_STEP_EN, 32'h0, RESP_OKAY);
		wr(OFF_IRQ_STAT, 32'h2, RESP_OKAY);
		wr(OFF_EXC_MASK, {24'h0, e}, RESP_OKAY);
		wr(OFF_IRQ_MASK, 32'h3, RESP_OKAY);
		bp = thread_iaddr[15:0] + 16'h0040;
		wr(OFF_BP_ADDR, {16'h0, bp}, RESP_OKAY);
		rd(OFF_BP_ADDR, {16'h0, bp}, RESP_OKAY);
		cmp_pin("irq_idle", 32'h0, {31'h0, irq});
		wr(OFF_BP_CTRL, 32'h1, RESP_OKAY);
		n = 0;
		do begin
			@(negedge aclk);
			guard(n);
		end while (debug_irq_pulse !== 1'b1);
		repeat (2) @(negedge aclk);
		cmp_pin("irq_hit", 32'h1, {31'h0, irq});
		cmp_pin("run_exc", {24'h0, ~e}, {24'h0, thread_run});
		rd(OFF_STEP_ACT, {24'h0, e}, RESP_OKAY);
		wr(OFF_BP_CTRL, 32'h0, RESP_OKAY);
		rd(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
		wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
		@(negedge aclk);
		cmp_pin("irq_masked", 32'h0, {31'h0, irq});
		wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
		wr(OFF_EXC_HALT, 32'hff, RESP_OKAY);
		rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
		@(negedge aclk);
		cmp_pin("run_free", 32'hff, {24'h0, thread_run});
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			k = 6'($urandom);
			@(posedge aclk);
			mirror_wr_en <= 1'b1;
			mirror_wr_idx <= k;
			mirror_wr_data <= v;
			@(posedge aclk);
			mirror_wr_en <= 1'b0;
			rd(OFF_MIR_BASE + {4'h0, k, 2'b00}, v, RESP_OKAY);
			wr(OFF_MIR_BASE + {4'h0, k, 2'b00}, ~v, RESP_SLVERR);
			rd(OFF_MIR_BASE + {4'h0, k, 2'b00}, v, RESP_OKAY);
		end
		rd(12'h080, 32'h0, RESP_SLVERR);
		wr(OFF_STEP_ACT, 32'hff, RESP_SLVERR);
		tally_and_finish();
	end
endmodule

// ### tb/tdsb_thread_model.sv
/*
 * Behavioural picoprocessor threads facing the debug block.
 * Assumes one core clock; a thread issues only while its run bit is high.
 */
`timescale 1ns/1ps
module tdsb_thread_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tdsb_pkg::THREADS-1:0] want,
	input wire logic [tdsb_pkg::THREADS-1:0] thread_run,
	output logic [tdsb_pkg::THREADS*tdsb_pkg::IA_W-1:0] thread_iaddr,
	output logic [tdsb_pkg::THREADS-1:0] thread_fetch
);
	import tdsb_pkg::*;
	// ------------------------------------------------------------
	// Issue and address advance
	// ------------------------------------------------------------
	// A thread asks to issue whenever the bench wants it, even while halted
	assign thread_fetch = want;

	always_ff @(posedge aclk) begin
		for (int t = 0; t < THREADS; t++) begin
			if (!aresetn)
				thread_iaddr[t*IA_W+:IA_W] <= '0;
			else if (want[t] && thread_run[t])
				thread_iaddr[t*IA_W+:IA_W] <= thread_iaddr[t*IA_W+:IA_W] + 16'h0001;
		end
	end
endmodule
